// ==== dv/dpvrb_host_model.sv ====
// host-side model issuing decoded register commands to the bank
`timescale 1ns/1ns
module dpvrb_host_model (
  // clock
  input wire logic sys_clk_in,
  // read answer from the bank
  input wire logic rd_valid_in,
  input wire logic [8:0] rd_data_in,
  // command port
  output logic cmd_valid_out,
  output dpvrb_pkg::dpvrb_cmd_t cmd_out,
  output logic cmd_done_out
);
  import dpvrb_pkg::*;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    cmd_done_out = 1'b0;
  end

  // one command per call; done may ride along or follow later
  task automatic issue(input dpvrb_op_t op, input logic [3:0] addr, input logic [8:0] data,
                       input logic done);
    @(posedge sys_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_out <= '{op: op, addr: addr, data: data};
    cmd_done_out <= done;
    @(posedge sys_clk_in);
    cmd_valid_out <= 1'b0;
    cmd_done_out <= 1'b0;
    // idle fields never repeat the last command
    cmd_out <= dpvrb_cmd_t'(~cmd_out);
  endtask : issue

  // answer is registered, so it stands just after the taking edge
  task automatic read(input logic [3:0] addr, output logic [8:0] data, output logic seen);
    issue(dpvrb_op_read, addr, 9'h000, 1'b0);
    #1;
    seen = rd_valid_in;
    data = rd_data_in;
  endtask : read

  // end of a serial command sent on its own
  task automatic finish;
    @(posedge sys_clk_in);
    cmd_done_out <= 1'b1;
    @(posedge sys_clk_in);
    cmd_done_out <= 1'b0;
  endtask : finish

  // after a brown-out the host puts back its own terminal setup
  task automatic restore_termctl(input logic [8:0] cfg);
    issue(dpvrb_op_write, 4'h4, cfg, 1'b1);
  endtask : restore_termctl
endmodule : dpvrb_host_model

// ==== dv/dpvrb_register_bank_tb.sv ====
// self-checking bench for the volatile register bank
`timescale 1ns/1ns
`include "dpvrb_regs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module dpvrb_register_bank_tb;
  import dpvrb_pkg::*;
  localparam logic [3:0] a_w0 = `DPVRB_ADDR_WIPER0;
  localparam logic [3:0] a_w1 = `DPVRB_ADDR_WIPER1;
  localparam logic [3:0] a_tc = `DPVRB_ADDR_TERMCTL;
  localparam logic [3:0] a_st = `DPVRB_ADDR_STATUS;
  logic sys_clk;
  logic reset_n;
  logic supply_ok;
  logic pin_shutdown_n;
  logic cmd_valid;
  dpvrb_cmd_t cmd;
  logic cmd_done;
  logic rd_valid;
  logic [8:0] rd_data;
  logic cmd_ignored;
  logic ready;
  logic [8:0] wiper0;
  logic [8:0] wiper1;
  dpvrb_switch_t net0_sw;
  dpvrb_switch_t net1_sw;
  int failures = 0;
  int tests_run = 0;
  logic [8:0] val;
  logic seen;

  dpvrb_register_bank DUT (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .supply_ok_in(supply_ok),
    .hw_shutdown_input_n_in(pin_shutdown_n), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .cmd_done_in(cmd_done), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
    .cmd_ignored_out(cmd_ignored), .digital_ready_out(ready), .wiper0_out(wiper0),
    .wiper1_out(wiper1), .net0_switch_out(net0_sw), .net1_switch_out(net1_sw)
  );

  dpvrb_host_model u_host (
    .sys_clk_in(sys_clk), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .cmd_done_out(cmd_done)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic results;
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic rd_chk(input logic [3:0] addr, input logic [8:0] exp);
    u_host.read(addr, val, seen);
    `CHK(seen, 1'b1)
    `CHK(val, exp)
  endtask : rd_chk

  task automatic wr_chk(input dpvrb_op_t op, input logic [3:0] addr, input logic [8:0] data,
                        input logic done, input logic ign);
    u_host.issue(op, addr, data, done);
    #1;
    `CHK(cmd_ignored, ign)
  endtask : wr_chk

  task automatic wait_ready;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(ready, 1'b1)
  endtask : wait_ready

  task automatic sw_chk(input logic [3:0] exp0, input logic [3:0] exp1);
    `CHK(net0_sw, exp0)
    `CHK(net1_sw, exp1)
  endtask : sw_chk

  // run is about 150 cycles; this bound only catches a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    results();
  end

  initial begin
    reset_n = 1'b0;
    supply_ok = 1'b1;
    pin_shutdown_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_ready();
    sw_chk(4'he, 4'he);
    rd_chk(a_w0, 9'h080);
    rd_chk(a_w1, 9'h080);
    rd_chk(a_tc, 9'h1ff);
    rd_chk(a_st, 9'h1e0);
    // unimplemented locations read zero and drop writes
    for (int a = 2; a < 16; a++) begin
      if (a != 4 && a != 5) begin
        rd_chk(4'(a), 9'h000);
        wr_chk(dpvrb_op_write, 4'(a), 9'h1aa, 1'b1, 1'b1);
      end
    end
    wr_chk(dpvrb_op_write, a_st, 9'h000, 1'b1, 1'b1);
    rd_chk(a_st, 9'h1e0);
    rd_chk(a_tc, 9'h1ff);
    // steps at control are dropped; above full scale a decrement holds
    wr_chk(dpvrb_op_incr, a_tc, 9'h000, 1'b1, 1'b1);
    rd_chk(a_tc, 9'h1ff);
    wr_chk(dpvrb_op_write, a_w0, 9'h1aa, 1'b1, 1'b0);
    wr_chk(dpvrb_op_decr, a_w0, 9'h000, 1'b1, 1'b0);
    rd_chk(a_w0, 9'h1aa);
    // steps at both scale ends
    wr_chk(dpvrb_op_write, a_w0, 9'h0ff, 1'b1, 1'b0);
    u_host.issue(dpvrb_op_incr, a_w0, 9'h000, 1'b1);
    rd_chk(a_w0, 9'h100);
    u_host.issue(dpvrb_op_incr, a_w0, 9'h000, 1'b1);
    rd_chk(a_w0, 9'h100);
    wr_chk(dpvrb_op_write, a_w1, 9'h000, 1'b1, 1'b0);
    u_host.issue(dpvrb_op_decr, a_w1, 9'h000, 1'b1);
    rd_chk(a_w1, 9'h000);
    wr_chk(dpvrb_op_write, a_w1, 9'h041, 1'b1, 1'b0);
    u_host.issue(dpvrb_op_decr, a_w1, 9'h000, 1'b1);
    rd_chk(a_w1, 9'h040);
    // control value waits for the end of its command
    wr_chk(dpvrb_op_write, a_tc, 9'h05a, 1'b0, 1'b0);
    rd_chk(a_tc, 9'h15a);
    sw_chk(4'he, 4'he);
    u_host.finish();
    @(posedge sys_clk);
    #1;
    sw_chk(4'h4, 4'h7);
    `CHK(wiper0, 9'h100)
    // pin shutdown overrides both networks
    @(posedge sys_clk);
    pin_shutdown_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    sw_chk(4'h7, 4'h7);
    rd_chk(a_st, 9'h1e2);
    wr_chk(dpvrb_op_write, a_w1, 9'h033, 1'b1, 1'b0);
    rd_chk(a_w1, 9'h033);
    `CHK(wiper1, 9'h033)
    rd_chk(a_tc, 9'h15a);
    @(posedge sys_clk);
    pin_shutdown_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    sw_chk(4'h4, 4'h7);
    rd_chk(a_st, 9'h1e0);
    // brown-out: commands dropped, defaults back on recovery
    @(posedge sys_clk);
    supply_ok <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(ready, 1'b0)
    wr_chk(dpvrb_op_write, a_w0, 9'h011, 1'b1, 1'b1);
    @(posedge sys_clk);
    supply_ok <= 1'b1;
    wait_ready();
    rd_chk(a_w0, 9'h080);
    rd_chk(a_tc, 9'h1ff);
    sw_chk(4'he, 4'he);
    u_host.restore_termctl(9'h0ee);
    repeat (2) @(posedge sys_clk);
    #1;
    sw_chk(4'hc, 4'hc);
    results();
  end
endmodule : dpvrb_register_bank_tb

// ==== hw/dpvrb_net_switch.sv ====
// terminal switch control of one resistor network
`timescale 1ns/1ns
`include "dpvrb_regs.svh"
module dpvrb_net_switch (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // control nibble and pin shutdown
  input wire logic [3:0] ctl_nibble_in,
  input wire logic shutdown_active_in,
  // switch controls
  output dpvrb_pkg::dpvrb_switch_t switch_out
);
  import dpvrb_pkg::*;

  logic forced;
  dpvrb_switch_t nxt_switch;

  // pin or force bit overrides the nibble without touching it
  assign forced = shutdown_active_in | ~ctl_nibble_in[`DPVRB_NIB_FORCE];

  always_comb begin
    if (forced) begin
      nxt_switch = '{term_a: 1'b0, wiper: 1'b1, term_b: 1'b1, wiper_to_b: 1'b1};
    end else begin
      nxt_switch.term_a = ctl_nibble_in[`DPVRB_NIB_A];
      nxt_switch.wiper = ctl_nibble_in[`DPVRB_NIB_W];
      nxt_switch.term_b = ctl_nibble_in[`DPVRB_NIB_B];
      nxt_switch.wiper_to_b = 1'b0;
    end
  end

  // reset matches the all-connected default
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      switch_out <= '{term_a: 1'b1, wiper: 1'b1, term_b: 1'b1, wiper_to_b: 1'b0};
    end else begin
      switch_out <= nxt_switch;
    end
  end
endmodule : dpvrb_net_switch

// ==== hw/dpvrb_pkg.sv ====
// types shared by the volatile register bank modules
package dpvrb_pkg;
  typedef enum logic [1:0] {
    dpvrb_op_write,
    dpvrb_op_incr,
    dpvrb_op_decr,
    dpvrb_op_read
  } dpvrb_op_t;

  typedef struct packed {
    dpvrb_op_t op;
    logic [3:0] addr;
    logic [8:0] data;
  } dpvrb_cmd_t;

  typedef struct packed {
    logic term_a;
    logic wiper;
    logic term_b;
    logic wiper_to_b;
  } dpvrb_switch_t;

  typedef enum logic [1:0] {
    dpvrb_pwr_down,
    dpvrb_pwr_load,
    dpvrb_pwr_run
  } dpvrb_pwr_t;
endpackage : dpvrb_pkg

// ==== hw/dpvrb_register_bank.sv ====
// volatile register bank of a one- or two-network digital potentiometer
`timescale 1ns/1ns
`include "dpvrb_regs.svh"
module dpvrb_register_bank #(
  parameter int WIPER_BITS = `DPVRB_WIPER_BITS,
  parameter int NUM_NETS = `DPVRB_NUM_NETS
) (
  // clock and power-on reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // supply trip detector and shutdown pin
  input wire logic supply_ok_in,
  input wire logic hw_shutdown_input_n_in,
  // decoded serial commands
  input wire logic cmd_valid_in,
  input wire dpvrb_pkg::dpvrb_cmd_t cmd_in,
  input wire logic cmd_done_in,
  // read answer and command status
  output logic rd_valid_out,
  output logic [8:0] rd_data_out,
  output logic cmd_ignored_out,
  output logic digital_ready_out,
  // wiper positions
  output logic [8:0] wiper0_out,
  output logic [8:0] wiper1_out,
  // terminal switch controls
  output dpvrb_pkg::dpvrb_switch_t net0_switch_out,
  output dpvrb_pkg::dpvrb_switch_t net1_switch_out
);
  import dpvrb_pkg::*;

  localparam logic [8:0] WIPER_MID = (WIPER_BITS == 8) ? `DPVRB_MID_8BIT : `DPVRB_MID_7BIT;
  localparam logic [8:0] WIPER_FULL = (WIPER_BITS == 8) ? `DPVRB_FULL_8BIT : `DPVRB_FULL_7BIT;

  generate
    if ((WIPER_BITS != 7 && WIPER_BITS != 8) || NUM_NETS < 1 || NUM_NETS > 2) begin : g_bad_param
      $error("dpvrb_register_bank: WIPER_BITS must be 7 or 8, NUM_NETS 1 or 2");
    end
  endgenerate

  // wiper register index hit, address 01h only on dual parts
  function automatic logic dpvrb_wiper_hit(input logic [3:0] addr, input int idx);
    logic hit;
    hit = (addr == 4'(idx)) && (idx < NUM_NETS);
    return hit;
  endfunction : dpvrb_wiper_hit

  // step within zero..full scale; above full scale both steps are held
  function automatic logic [8:0] dpvrb_step(input logic [8:0] cur, input dpvrb_op_t op);
    logic [8:0] res;
    res = cur;
    if (op == dpvrb_op_incr && cur < WIPER_FULL) begin
      res = cur + 9'h001;
    end else if (op == dpvrb_op_decr && cur != 9'h000 && cur <= WIPER_FULL) begin
      res = cur - 9'h001;
    end
    return res;
  endfunction : dpvrb_step

  logic supply_ok_sync;
  logic shutdown_n_sync;
  logic shutdown_act;
  logic cmd_go;
  logic writable_hit;
  dpvrb_pwr_t pwr_ff;
  dpvrb_pwr_t nxt_pwr;
  logic [8:0] wiper_ff [0:1];
  logic [7:0] termctl_ff;
  logic [7:0] nxt_termctl;
  logic [7:0] termctl_live_ff;
  logic rd_valid_ff;
  logic [8:0] rd_data_ff;
  logic [8:0] nxt_rd_data;
  logic cmd_ignored_ff;
  logic ready_ff;

  // pin levels come from outside the clock domain
  dpvrb_sync2 #(
    .RESET_VAL(1'b0)
  ) u_supply_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(supply_ok_in),
    .sync_out(supply_ok_sync)
  );

  dpvrb_sync2 #(
    .RESET_VAL(1'b1)
  ) u_shutdown_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(hw_shutdown_input_n_in),
    .sync_out(shutdown_n_sync)
  );

  assign shutdown_act = ~shutdown_n_sync;

  // power sequencing: down, one load cycle, then run
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      dpvrb_pwr_down: begin
        if (supply_ok_sync) begin
          nxt_pwr = dpvrb_pwr_load;
        end
      end
      dpvrb_pwr_load: begin
        nxt_pwr = supply_ok_sync ? dpvrb_pwr_run : dpvrb_pwr_down;
      end
      dpvrb_pwr_run: begin
        if (!supply_ok_sync) begin
          nxt_pwr = dpvrb_pwr_down;
        end
      end
      default: begin
        nxt_pwr = dpvrb_pwr_down;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwr_ff <= dpvrb_pwr_down;
      ready_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      ready_ff <= (nxt_pwr == dpvrb_pwr_run);
    end
  end

  // pin shutdown does not gate the command path
  assign cmd_go = cmd_valid_in && (pwr_ff == dpvrb_pwr_run);

  // only wipers and control take writes; steps only reach wipers
  always_comb begin
    writable_hit = dpvrb_wiper_hit(cmd_in.addr, 0) || dpvrb_wiper_hit(cmd_in.addr, 1);
    if (cmd_in.op == dpvrb_op_write && cmd_in.addr == `DPVRB_ADDR_TERMCTL) begin
      writable_hit = 1'b1;
    end
    if (cmd_in.op == dpvrb_op_read) begin
      writable_hit = 1'b1;
    end
  end

  // wiper registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wiper_ff[0] <= WIPER_MID;
      wiper_ff[1] <= WIPER_MID;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pwr_ff == dpvrb_pwr_load) begin
          wiper_ff[i] <= WIPER_MID;
        end else if (cmd_go && dpvrb_wiper_hit(cmd_in.addr, i)) begin
          if (cmd_in.op == dpvrb_op_write) begin
            wiper_ff[i] <= cmd_in.data;
          end else begin
            wiper_ff[i] <= dpvrb_step(wiper_ff[i], cmd_in.op);
          end
        end
      end
    end
  end

  // control register; the top bit is not stored and always reads one
  always_comb begin
    nxt_termctl = termctl_ff;
    if (pwr_ff == dpvrb_pwr_load) begin
      nxt_termctl = 8'(`DPVRB_TERMCTL_RESET);
    end else if (cmd_go && cmd_in.op == dpvrb_op_write
                 && cmd_in.addr == `DPVRB_ADDR_TERMCTL) begin
      nxt_termctl = cmd_in.data[7:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      termctl_ff <= 8'(`DPVRB_TERMCTL_RESET);
    end else begin
      termctl_ff <= nxt_termctl;
    end
  end

  // switches follow the stored bits only once the command has ended or in the power-up load cycle
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      termctl_live_ff <= 8'(`DPVRB_TERMCTL_RESET);
    end else if (pwr_ff == dpvrb_pwr_load || cmd_done_in) begin
      termctl_live_ff <= nxt_termctl;
    end
  end

  // read mux
  always_comb begin
    nxt_rd_data = `DPVRB_RSVD_READ;
    if (dpvrb_wiper_hit(cmd_in.addr, 0)) begin
      nxt_rd_data = wiper_ff[0];
    end else if (dpvrb_wiper_hit(cmd_in.addr, 1)) begin
      nxt_rd_data = wiper_ff[1];
    end else if (cmd_in.addr == `DPVRB_ADDR_TERMCTL) begin
      nxt_rd_data = {1'b1, termctl_ff};
    end else if (cmd_in.addr == `DPVRB_ADDR_STATUS) begin
      nxt_rd_data = {`DPVRB_STATUS_ONES, `DPVRB_STATUS_RSVD, shutdown_act, 1'b0};
    end
  end

  // reserved locations answer with a fixed value
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= `DPVRB_RSVD_READ;
    end else begin
      rd_valid_ff <= cmd_go && cmd_in.op == dpvrb_op_read;
      if (cmd_go && cmd_in.op == dpvrb_op_read) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  // flags commands dropped below trip or aimed at nothing writable
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_ignored_ff <= 1'b0;
    end else begin
      cmd_ignored_ff <= cmd_valid_in && (!cmd_go || !writable_hit);
    end
  end

  dpvrb_net_switch u_net0 (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .ctl_nibble_in(termctl_live_ff[3:0]),
    .shutdown_active_in(shutdown_act),
    .switch_out(net0_switch_out)
  );

  // single-network parts still drive this control from the upper nibble of the control register
  dpvrb_net_switch u_net1 (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .ctl_nibble_in(termctl_live_ff[7:4]),
    .shutdown_active_in(shutdown_act),
    .switch_out(net1_switch_out)
  );

  assign rd_valid_out = rd_valid_ff;
  assign rd_data_out = rd_data_ff;
  assign cmd_ignored_out = cmd_ignored_ff;
  assign digital_ready_out = ready_ff;
  assign wiper0_out = wiper_ff[0];
  assign wiper1_out = wiper_ff[1];

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_power_up;
    pwr_ff == dpvrb_pwr_down ##1 pwr_ff == dpvrb_pwr_load;
  endsequence

  sequence s_read_at(logic [3:0] a);
    cmd_go && cmd_in.op == dpvrb_op_read && cmd_in.addr == a;
  endsequence

  power_up_load_a: assert property (
    s_power_up |=> termctl_ff == 8'hff && wiper_ff[0] == WIPER_MID && wiper_ff[1] == WIPER_MID)
    else $error("defaults not loaded after supply rise");

  termctl_read_a: assert property (
    s_read_at(`DPVRB_ADDR_TERMCTL) |=> rd_valid_ff && rd_data_ff == {1'b1, $past(termctl_ff)})
    else $error("control read wrong");

  status_read_a: assert property (
    s_read_at(`DPVRB_ADDR_STATUS)
      |=> rd_data_ff[8:5] == 4'hf && rd_data_ff[1] == $past(shutdown_act)
      && rd_data_ff[0] == 1'b0)
    else $error("status read wrong");

  below_trip_ignore_a: assert property (
    cmd_valid_in && pwr_ff == dpvrb_pwr_down
      |=> !rd_valid_ff && cmd_ignored_ff && $stable(wiper_ff[0]) && $stable(termctl_ff))
    else $error("command acted below trip point");

  wiper_incr_a: assert property (
    cmd_go && cmd_in.op == dpvrb_op_incr && cmd_in.addr == `DPVRB_ADDR_WIPER0
      && wiper_ff[0] < WIPER_FULL |=> wiper_ff[0] == $past(wiper_ff[0]) + 9'h001)
    else $error("increment did not step");

  full_scale_hold_a: assert property (
    cmd_go && cmd_in.op == dpvrb_op_incr && cmd_in.addr == `DPVRB_ADDR_WIPER0
      && wiper_ff[0] >= WIPER_FULL |=> $stable(wiper_ff[0]))
    else $error("increment passed full scale");

  rsvd_write_a: assert property (
    cmd_go && cmd_in.op == dpvrb_op_write && (cmd_in.addr == `DPVRB_ADDR_STATUS
      || cmd_in.addr > `DPVRB_ADDR_STATUS || cmd_in.addr == 4'h2 || cmd_in.addr == 4'h3)
      |=> $stable(termctl_ff) && $stable(wiper_ff[0]) && $stable(wiper_ff[1]) && cmd_ignored_ff)
    else $error("reserved write changed state");

  termctl_apply_a: assert property (
    !cmd_done_in && pwr_ff != dpvrb_pwr_load |=> $stable(termctl_live_ff))
    else $error("control applied before command end");

  termctl_wiper_a: assert property (
    cmd_go && cmd_in.op == dpvrb_op_write && cmd_in.addr == `DPVRB_ADDR_TERMCTL
      |=> $stable(wiper_ff[0]) && $stable(wiper_ff[1]))
    else $error("control write moved a wiper");

  shutdown_override_a: assert property (
    shutdown_act |=> !net0_switch_out.term_a && net0_switch_out.wiper_to_b
      && !net1_switch_out.term_a && net1_switch_out.wiper_to_b)
    else $error("pin shutdown not applied");

  shutdown_keep_a: assert property (
    shutdown_act && !(cmd_go && cmd_in.addr == `DPVRB_ADDR_TERMCTL) && pwr_ff == dpvrb_pwr_run
      ##1 shutdown_act |-> $stable(termctl_ff))
    else $error("pin shutdown altered control bits");

  connect_follow_a: assert property (
    !shutdown_act && termctl_live_ff[3]
      |=> net0_switch_out.term_a == $past(termctl_live_ff[2])
      && net0_switch_out.term_b == $past(termctl_live_ff[0]) && !net0_switch_out.wiper_to_b)
    else $error("switch does not follow connect bit");
endmodule : dpvrb_register_bank

// ==== hw/dpvrb_regs.svh ====
// register map, field positions, reset values and sizes of the volatile bank
`ifndef DPVRB_REGS_SVH
`define DPVRB_REGS_SVH
`define DPVRB_NUM_LOCATIONS 16
`define DPVRB_DATA_BITS 9
`define DPVRB_ADDR_WIPER0 4'h0
`define DPVRB_ADDR_WIPER1 4'h1
`define DPVRB_ADDR_TERMCTL 4'h4
`define DPVRB_ADDR_STATUS 4'h5
`define DPVRB_TERMCTL_RESET 9'h1ff
`define DPVRB_TERMCTL_TOP_BIT 8
`define DPVRB_STATUS_ONES 4'hf
`define DPVRB_STATUS_SHUTDOWN_BIT 1
`define DPVRB_STATUS_RSVD 3'h0
`define DPVRB_RSVD_READ 9'h000
`define DPVRB_NIB_FORCE 3
`define DPVRB_NIB_A 2
`define DPVRB_NIB_W 1
`define DPVRB_NIB_B 0
`define DPVRB_MID_8BIT 9'h080
`define DPVRB_MID_7BIT 9'h040
`define DPVRB_FULL_8BIT 9'h100
`define DPVRB_FULL_7BIT 9'h080
`define DPVRB_WIPER_BITS 8
`define DPVRB_NUM_NETS 2
`endif

// ==== hw/dpvrb_sync2.sv ====
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
module dpvrb_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_ff <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : dpvrb_sync2
